// ===== include/adc_ctl_pkg.sv
package adc_ctl_pkg;

    // Channel count and conversion length
    localparam int NCHAN = 4;
    localparam logic [4:0] CONV_CYCLES = 5'd16;

    // Internal master clock divider, in pclk cycles per master period
    localparam logic [7:0] INT_CLK_DIV = 8'h12;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHSEL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // Control register fields
    localparam int CTRL_SW_START = 0;

    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_EXT_CLK = 1;
    localparam int ST_STANDBY = 2;
    localparam int ST_HW_MODE = 3;
    localparam int ST_MASK_LO = 4;
    localparam int ST_CHAN_LO = 8;

    // Interrupt status and mask fields
    localparam int NIRQ = 3;
    localparam int IRQ_EOC = 0;
    localparam int IRQ_SEQ_DONE = 1;
    localparam int IRQ_OVERRUN = 2;

    // Reset values
    localparam logic [3:0] CHSEL_RESET = 4'h0;
    localparam logic [NIRQ-1:0] IRQ_RESET = 3'h0;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_CONV = 3'b010,
        SEQ_EOC = 3'b100
    } seq_state_t;

    // Parallel strobe port of the device
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] data;
    } par_bus_t;

    // Mode and channel select pins
    typedef struct packed {
        logic hw_sw_select;
        logic hw_include_chan_d;
        logic hw_include_chan_c;
        logic hw_include_chan_b;
        logic hw_include_chan_a;
    } sel_pins_t;

    // State of the clock tick generator
    typedef struct packed {
        logic [7:0] div_cnt;
        logic ext_prev;
        logic tick;
    } tick_state_t;

    // State of the control block
    typedef struct packed {
        seq_state_t state;
        logic [3:0] mask;
        logic [3:0] pend;
        logic [1:0] chan;
        logic [4:0] cnt;
        logic use_ext;
        logic busy;
        logic eoc_n;
        logic [3:0] chsel;
        logic wr_prev;
        logic cvt_prev;
        logic [NIRQ-1:0] irq_stat;
        logic [NIRQ-1:0] irq_mask;
        logic [31:0] prdata;
    } ctl_state_t;

endpackage

// ===== core/master_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module master_tick_gen
    import adc_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic use_ext,
    input wire logic ext_clk,
    output logic tick
);

    tick_state_t s_r;
    tick_state_t s_nxt;

    // One enable per master period, internal divider or external edge
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.ext_prev = ext_clk;
        if (!run) begin
            s_nxt.div_cnt = 8'h00;
        end else if (use_ext) begin
            s_nxt.tick = ext_clk & ~s_r.ext_prev;
        end else if (s_r.div_cnt == INT_CLK_DIV - 8'h01) begin
            s_nxt.div_cnt = 8'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule
`default_nettype wire

// ===== core/adc_seq_ctl.sv
// Notes on behaviour
// - WR rising edge, CS low, RD high latches
// - Software mode: shared pins become clock inputs
// - Each channel conversion takes 16 master clocks
// - Clock choice 0 internal, 1 external
// - Hardware mode: pin high includes its channel
// - Select pins captured at convert start edge
// - Hardware mode uses pins and internal clock
// - Software mode uses register, either clock
// - Standby input low enters power save
// - Register bit 0 channel 1, bit 3 channel 4
// - Convert start rising edge holds and converts
// - Low pulse on end-of-conversion per channel
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctl
    import adc_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire par_bus_t par,
    input wire sel_pins_t pins,
    input wire logic convert_start,
    input wire logic power_save_n,
    output logic busy,
    output logic eoc_n,
    output logic hold,
    output logic [1:0] conv_chan,
    output logic irq
);

    ctl_state_t s_r;
    ctl_state_t s_nxt;
    logic tick;
    logic sw_mode;
    logic clk_choice;
    logic [3:0] hw_sel;
    logic setup_ph;
    logic access_wr;
    logic addr_ok;
    logic sw_start;
    logic start_req;
    logic par_wr;
    logic [3:0] start_mask;
    logic [1:0] first_chan;
    logic [1:0] next_chan;
    logic [3:0] pend_after;
    logic [NIRQ-1:0] irq_set;
    logic [NIRQ-1:0] irq_clr;

    // Shared pins change meaning with the mode input
    assign sw_mode = pins.hw_sw_select;
    assign clk_choice = pins.hw_include_chan_b;
    assign hw_sel = {pins.hw_include_chan_d, pins.hw_include_chan_c,
                     pins.hw_include_chan_b, pins.hw_include_chan_a};

    // Master clock enable for the running conversion
    master_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(s_r.state == SEQ_CONV),
        .use_ext(s_r.use_ext),
        .ext_clk(pins.hw_include_chan_a),
        .tick(tick)
    );

    // APB phase decode
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite & addr_ok;
    assign sw_start = access_wr && paddr == OFS_CTRL
                      && pwdata[CTRL_SW_START];

    // Address map check
    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_CHSEL, OFS_STATUS,
            OFS_IRQ_STAT, OFS_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Parallel strobe write detect
    assign par_wr = par.wr_n & ~s_r.wr_prev & ~par.cs_n & par.rd_n;

    // Sequence source and start request
    assign start_mask = sw_mode ? s_r.chsel : hw_sel;
    assign start_req = (convert_start & ~s_r.cvt_prev) | sw_start;

    // Lowest pending channel for the start and for the next step
    always_comb begin
        first_chan = 2'd0;
        next_chan = 2'd0;
        pend_after = s_r.pend;
        pend_after[s_r.chan] = 1'b0;
        for (int i = NCHAN - 1; i >= 0; i--) begin
            if (start_mask[i]) begin
                first_chan = 2'(i);
            end
            if (pend_after[i]) begin
                next_chan = 2'(i);
            end
        end
    end

    // Interrupt clear by writing ones
    always_comb begin
        irq_clr = '0;
        if (access_wr && paddr == OFS_IRQ_STAT) begin
            irq_clr = pwdata[NIRQ-1:0];
        end
    end

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;
        irq_set = '0;
        s_nxt.wr_prev = par.wr_n;
        s_nxt.cvt_prev = convert_start;
        s_nxt.eoc_n = 1'b1;

        // Channel select register, strobe port wins over APB
        if (par_wr) begin
            s_nxt.chsel = par.data;
        end else if (access_wr && paddr == OFS_CHSEL) begin
            s_nxt.chsel = pwdata[3:0];
        end

        // Interrupt mask register
        if (access_wr && paddr == OFS_IRQ_MASK) begin
            s_nxt.irq_mask = pwdata[NIRQ-1:0];
        end

        // Conversion sequencer
        case (s_r.state)
            SEQ_IDLE: begin
                if (start_req && power_save_n && start_mask != 4'h0) begin
                    s_nxt.state = SEQ_CONV;
                    s_nxt.mask = start_mask;
                    s_nxt.pend = start_mask;
                    s_nxt.chan = first_chan;
                    s_nxt.cnt = 5'd0;
                    s_nxt.use_ext = sw_mode & clk_choice;
                    s_nxt.busy = 1'b1;
                end
            end
            SEQ_CONV: begin
                if (tick) begin
                    if (s_r.cnt == CONV_CYCLES - 5'd1) begin
                        s_nxt.state = SEQ_EOC;
                        s_nxt.pend = pend_after;
                        s_nxt.eoc_n = 1'b0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 5'd1;
                    end
                end
                if (start_req) begin
                    irq_set[IRQ_OVERRUN] = 1'b1;
                end
            end
            SEQ_EOC: begin
                irq_set[IRQ_EOC] = 1'b1;
                if (s_r.pend == 4'h0) begin
                    s_nxt.state = SEQ_IDLE;
                    s_nxt.busy = 1'b0;
                    irq_set[IRQ_SEQ_DONE] = 1'b1;
                end else begin
                    s_nxt.state = SEQ_CONV;
                    s_nxt.chan = next_chan;
                    s_nxt.cnt = 5'd0;
                end
                if (start_req) begin
                    irq_set[IRQ_OVERRUN] = 1'b1;
                end
            end
            default: begin
                s_nxt.state = SEQ_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase

        // Standby aborts any sequence and blocks new ones
        if (!power_save_n) begin
            s_nxt.state = SEQ_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.pend = 4'h0;
            s_nxt.eoc_n = 1'b1;
        end

        // Sticky status, set wins over clear
        s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;

        // Read data captured in the setup phase
        if (setup_ph) begin
            s_nxt.prdata = 32'h0000_0000;
            case (paddr)
                OFS_CHSEL: s_nxt.prdata[3:0] = s_r.chsel;
                OFS_STATUS: begin
                    s_nxt.prdata[ST_BUSY] = s_r.busy;
                    s_nxt.prdata[ST_EXT_CLK] = s_r.use_ext;
                    s_nxt.prdata[ST_STANDBY] = ~power_save_n;
                    s_nxt.prdata[ST_HW_MODE] = ~sw_mode;
                    s_nxt.prdata[ST_MASK_LO +: 4] = s_r.mask;
                    s_nxt.prdata[ST_CHAN_LO +: 2] = s_r.chan;
                end
                OFS_IRQ_STAT: s_nxt.prdata[NIRQ-1:0] = s_r.irq_stat;
                OFS_IRQ_MASK: s_nxt.prdata[NIRQ-1:0] = s_r.irq_mask;
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.state <= SEQ_IDLE;
            s_r.mask <= 4'h0;
            s_r.pend <= 4'h0;
            s_r.chan <= 2'd0;
            s_r.cnt <= 5'd0;
            s_r.use_ext <= 1'b0;
            s_r.busy <= 1'b0;
            s_r.eoc_n <= 1'b1;
            s_r.chsel <= CHSEL_RESET;
            s_r.wr_prev <= 1'b1;
            s_r.cvt_prev <= 1'b1;
            s_r.irq_stat <= IRQ_RESET;
            s_r.irq_mask <= IRQ_RESET;
            s_r.prdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign busy = s_r.busy;
    assign eoc_n = s_r.eoc_n;
    assign hold = s_r.busy;
    assign conv_chan = s_r.chan;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);

endmodule
`default_nettype wire

// ===== dv/adc_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_save_n,
    input wire logic busy,
    input wire logic eoc_n,
    input wire logic hold,
    input wire logic [1:0] conv_chan
);
    logic [9:0] len_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the running channel began
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r <= 10'h000;
        end else if (!busy || !eoc_n) begin
            len_r <= 10'h000;
        end else if (len_r != 10'h3ff) begin
            len_r <= len_r + 10'h001;
        end
    end
    chk_eoc_pulse: assert property (!eoc_n |=> eoc_n)
        else $error("eoc pulse too long");
    chk_eoc_busy: assert property (!eoc_n |-> busy)
        else $error("eoc outside sequence");
    chk_hold_busy: assert property (hold == busy)
        else $error("hold differs from busy");
    // Sixteen master clocks, each at least two pclk long
    chk_conv_len: assert property (!eoc_n |-> len_r >= 10'h020)
        else $error("channel too short");
    chk_chan_up: assert property (
        !eoc_n |=> !busy || conv_chan > $past(conv_chan))
        else $error("channel order wrong");
    chk_standby_abort: assert property (!power_save_n |=> !busy)
        else $error("busy in standby");
    chk_pready_high: assert property (psel && penable |-> pready)
        else $error("no ready");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule
bind adc_seq_ctl adc_seq_chk chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .power_save_n(power_save_n), .busy(busy), .eoc_n(eoc_n),
    .hold(hold), .conv_chan(conv_chan));
`default_nettype wire

// ===== dv/host_par.sv
`timescale 1ns/1ps
`default_nettype none
module host_par
    import adc_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic ext_on,
    output var par_bus_t par,
    output logic ext_clk
);
    logic [1:0] ph;
    initial begin
        par = '{1'b1, 1'b1, 1'b1, 4'h5};
        ext_clk = 1'b0;
        ph = 2'h0;
    end
    // Even duty clock, still unless selected
    always @(posedge pclk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (ext_on && ph == 2'h2) ext_clk <= ~ext_clk;
    end
    // Strobe write; rd is the read strobe level held meanwhile
    task automatic wr(input logic [3:0] d, input logic rd);
        @(posedge pclk);
        par <= '{1'b0, rd, 1'b0, d};
        @(posedge pclk);
        par.wr_n <= 1'b1;
        @(posedge pclk);
        par <= '{1'b1, 1'b1, 1'b1, ~d};
    endtask
endmodule
`default_nettype wire

// ===== dv/adc_seq_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctl_tb import adc_ctl_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, cvt, psn, hs, xc, er;
    logic pready, pslverr, busy, eoc_n, hold, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] conv_chan;
    logic [3:0] sl;
    par_bus_t par;
    sel_pins_t pins;
    int mismatches, tests_run;
    assign pins = '{hs, sl[3], sl[2], sl[1], hs ? xc : sl[0]};
    adc_seq_ctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .par(par), .pins(pins), .convert_start(cvt),
        .power_save_n(psn), .busy(busy), .eoc_n(eoc_n), .hold(hold),
        .conv_chan(conv_chan), .irq(irq));
    host_par host_u (.pclk(pclk), .ext_on(hs & sl[1]), .par(par),
        .ext_clk(xc));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; result left in rd and er
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Start, restart while busy, check channel order and lengths
    task automatic seq(input logic [3:0] m, input int lo, input int hi);
        int n, t, c, k;
        logic [3:0] left;
        left = m;
        t = 0;
        for (n = 0; n < 2000 && (n < 2 || busy); n++) begin
            @(posedge pclk);
            cvt <= (n < 1) || (n == 4);
            if (n == 1 && !hs) sl <= ~sl;
            @(negedge pclk);
            t++;
            if (!eoc_n) begin
                c = 0;
                for (k = 3; k >= 0; k--) if (left[k]) c = k;
                chk(conv_chan, c);
                chk(t >= lo && t <= hi, 1);
                left[c] = 1'b0;
                t = 0;
            end
        end
        chk(left, 0);
        chk(busy, 1'b0);
    endtask
    task automatic conclude();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, cvt, hs} = 6'h00;
        {paddr, pwdata, sl, psn} = 45'h1;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset value and unmapped address
        apb(0, OFS_CHSEL, 0);
        chk(rd, 32'h0);
        apb(0, 8'h40, 0);
        chk(er, 1'b1);
        // Hardware mode, pins change mid-sequence
        sl <= 4'ha;
        seq(4'ha, 280, 300);
        apb(0, OFS_IRQ_STAT, 0);
        chk(rd, 32'h7);
        chk(irq, 1'b0);
        apb(1, OFS_IRQ_MASK, 32'h2);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1);
        apb(1, OFS_IRQ_STAT, 32'h7);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        // Software mode, strobe writes, internal then external clock
        hs <= 1'b1;
        sl <= 4'h0;
        host_u.wr(4'h5, 1'b1);
        host_u.wr(4'hf, 1'b0);
        apb(0, OFS_CHSEL, 0);
        chk(rd, 32'h5);
        seq(4'h5, 280, 300);
        @(posedge pclk) sl <= 4'h2;
        apb(1, OFS_CHSEL, 32'h8);
        seq(4'h8, 88, 106);
        // Standby aborts and blocks starts
        @(posedge pclk) sl <= 4'h0;
        @(posedge pclk) cvt <= 1'b1;
        repeat (4) @(negedge pclk);
        chk(busy, 1'b1);
        @(posedge pclk) psn <= 1'b0;
        cvt <= 1'b0;
        repeat (3) @(posedge pclk);
        cvt <= 1'b1;
        repeat (3) @(negedge pclk);
        chk(busy, 1'b0);
        // Register start after standby, status shows latched set
        @(posedge pclk) psn <= 1'b1;
        apb(1, OFS_CTRL, 32'h1);
        apb(0, OFS_STATUS, 0);
        chk(rd, 32'h381);
        conclude();
    end
endmodule
`default_nettype wire
